//--- hdl/lcdsp_fifo.sv
`timescale 1ns/100ps
module lcdsp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fill and drain sides
  lcdsp_stream_if.snk wr,
  lcdsp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic full;
  logic empty;

  assign empty = (wptr == rptr);
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (wr.valid && !full) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (wr.valid && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (rd.ready && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  a_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (!rst_b)
    full |=> (wptr - rptr) <= (AW+1)'(DEPTH))
    else $error("fifo fill count above depth");
endmodule // lcdsp_fifo

//--- hdl/lcdsp_pkg.sv
package lcdsp_pkg;
  // ****************************************************************
  // Address and framing
  // ****************************************************************
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam logic ADDR_PLAIN_DIR = 1'b0;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [7:0] BLOCK_BITS = 8'h80;
  localparam logic [3:0] BLOCK_LAST_BYTE = 4'hf;

  // ****************************************************************
  // Storage and display
  // ****************************************************************
  localparam int SREG_W = 128;
  localparam int FIFO_DEPTH = 16;
  localparam int GROUP_W = 32;
  localparam int NUM_BP = 4;
  localparam logic [7:0] OSC_DIV = 8'h08;

  // ****************************************************************
  // Synchroniser lane positions
  // ****************************************************************
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_ENB = 2;
  localparam int SY_STRAP_LSB = 3;
  localparam int SY_STRAP_MID = 4;
  localparam int SY_STRAP_MSB = 5;
  localparam int SY_ACK = 6;
  localparam int SY_OSC = 7;
  localparam int SY_W = 8;

  // Gray codes along idle, address, write
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WRITE = 3'h3,
    ST_READ = 3'h2,
    ST_SKIP = 3'h6
  } lcdsp_state_t;
endpackage

//--- hdl/lcdsp_port.sv
// Contract
// - Address is 0111 plus three straps
// - Ignore data until own address seen
// - All straps high means master role
// - Enable high: latch after 128 bits
// - Enable held low: latch on pulse
// - Latched data feeds display multiplexer
// - Clock and data idle high
// - Start: data falls, clock high
// - Plain variant: bit per clock, no acknowledge
// - Stop or restart releases addressed state
// - Plain: skip 129th edge, resume after
// - Open channel keeps latching per block
// - Stop aborts; needs start and address
// - Acknowledge variant: seven bits plus direction
// - Acknowledge address on ninth clock
// - Acknowledge each written byte low
// - Read shifts out register, oldest first
// - Read: release data on ninth clock
// - Acknowledge variant skips edge after block
// - One 32-bit group per backplane phase
// - Bit one drives segment on
// - Serial side independent of display timing
`timescale 1ns/100ps
module lcdsp_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial link
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic latch_enable_n,
  // Straps and variant
  input wire logic addr_strap_msb,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_lsb,
  input wire logic ack_mode,
  output logic master_role,
  // Display
  input wire logic osc_input,
  output logic osc_output,
  output logic [lcdsp_pkg::GROUP_W-1:0] frontplane_outputs,
  output logic [lcdsp_pkg::NUM_BP-1:0] backplane_outputs
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [lcdsp_pkg::SY_W-1:0] pins;
  logic [lcdsp_pkg::SY_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic enb_s;
  logic ack_mode_s;
  logic osc_s;
  logic [2:0] strap_s;
  logic scl_q;
  logic sda_q;
  logic enb_q;
  logic osc_q;

  assign pins = {osc_input, ack_mode, addr_strap_msb, addr_strap_mid, addr_strap_lsb,
                 latch_enable_n, serial_data_in, serial_clock_in};

  lcdsp_sync #(.W(lcdsp_pkg::SY_W)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(pins),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[lcdsp_pkg::SY_SCL];
  assign sda_s = pins_s[lcdsp_pkg::SY_SDA];
  assign enb_s = pins_s[lcdsp_pkg::SY_ENB];
  assign ack_mode_s = pins_s[lcdsp_pkg::SY_ACK];
  assign osc_s = pins_s[lcdsp_pkg::SY_OSC];
  assign strap_s = {pins_s[lcdsp_pkg::SY_STRAP_MSB], pins_s[lcdsp_pkg::SY_STRAP_MID],
                    pins_s[lcdsp_pkg::SY_STRAP_LSB]};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      enb_q <= 1'b1;
      osc_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      enb_q <= enb_s;
      osc_q <= osc_s;
    end
  end

  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic enb_rise;
  logic osc_rise;
  logic auto_mode;

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_cond = scl_s && scl_q && sda_q && !sda_s;
  assign stop_cond = scl_s && scl_q && !sda_q && sda_s;
  assign enb_rise = enb_s && !enb_q;
  assign osc_rise = osc_s && !osc_q;
  assign auto_mode = enb_s;

  // Straps are static; an all-ones strap elects this part as master
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_role <= 1'b0;
    end else begin
      master_role <= &strap_s;
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  lcdsp_pkg::lcdsp_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] data_bits;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic skip;
  logic addr_hit;
  logic rd_dir;
  logic ack_ok;
  logic [3:0] rd_byte;
  logic plain_hit;
  logic ack_hit;
  logic [lcdsp_pkg::SREG_W-1:0] sreg;
  logic [6:0] rd_idx;
  logic rd_bit;

  lcdsp_stream_if #(.W(lcdsp_pkg::BYTE_W)) wr_if ();
  lcdsp_stream_if #(.W(lcdsp_pkg::BYTE_W)) rd_if ();

  assign next_shreg = {shreg[6:0], sda_s};
  assign plain_hit = (next_shreg == {lcdsp_pkg::ADDR_FIXED, strap_s,
                                     lcdsp_pkg::ADDR_PLAIN_DIR});
  assign ack_hit = (next_shreg[7:1] == {lcdsp_pkg::ADDR_FIXED, strap_s});
  assign wr_if.data = shreg;
  assign rd_idx = {~rd_byte, 3'h7} - {4'h0, bit_cnt[2:0]};
  assign rd_bit = sreg[rd_idx];

  always_ff @(posedge core_clk or negedge rst_b) begin : rx_fsm
    if (!rst_b) begin
      state <= lcdsp_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      data_bits <= 8'h00;
      shreg <= 8'h00;
      skip <= 1'b0;
      addr_hit <= 1'b0;
      rd_dir <= 1'b0;
      ack_ok <= 1'b0;
      rd_byte <= 4'h0;
      wr_if.valid <= 1'b0;
    end else begin
      wr_if.valid <= 1'b0;
      if (start_cond) begin
        state <= lcdsp_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        data_bits <= 8'h00;
        skip <= 1'b0;
        addr_hit <= 1'b0;
        rd_byte <= 4'h0;
      end else if (stop_cond) begin
        state <= lcdsp_pkg::ST_IDLE;
        addr_hit <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          lcdsp_pkg::ST_ADDR: begin
            if (bit_cnt == lcdsp_pkg::BIT_ACK) begin
              bit_cnt <= 4'h0;
              if (!addr_hit) begin
                state <= lcdsp_pkg::ST_SKIP;
              end else if (rd_dir) begin
                state <= lcdsp_pkg::ST_READ;
              end else begin
                state <= lcdsp_pkg::ST_WRITE;
              end
            end else begin
              shreg <= next_shreg;
              if (bit_cnt == lcdsp_pkg::BIT_LAST) begin
                if (ack_mode_s) begin
                  bit_cnt <= lcdsp_pkg::BIT_ACK;
                  addr_hit <= ack_hit;
                  rd_dir <= sda_s;
                end else begin
                  bit_cnt <= 4'h0;
                  addr_hit <= plain_hit;
                  state <= plain_hit ? lcdsp_pkg::ST_WRITE : lcdsp_pkg::ST_SKIP;
                end
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          lcdsp_pkg::ST_WRITE: begin
            if (skip) begin
              skip <= 1'b0;
            end else if (bit_cnt == lcdsp_pkg::BIT_ACK) begin
              bit_cnt <= 4'h0;
              if (data_bits == lcdsp_pkg::BLOCK_BITS) begin
                skip <= 1'b1;
                data_bits <= 8'h00;
              end
            end else begin
              shreg <= next_shreg;
              data_bits <= data_bits + 8'h01;
              if (bit_cnt == lcdsp_pkg::BIT_LAST) begin
                // A full buffer drops the byte and withholds the acknowledge
                wr_if.valid <= 1'b1;
                ack_ok <= wr_if.ready;
                if (ack_mode_s) begin
                  bit_cnt <= lcdsp_pkg::BIT_ACK;
                end else begin
                  bit_cnt <= 4'h0;
                  if (data_bits == lcdsp_pkg::BLOCK_BITS - 8'h01) begin
                    skip <= 1'b1;
                    data_bits <= 8'h00;
                  end
                end
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          lcdsp_pkg::ST_READ: begin
            if (bit_cnt == lcdsp_pkg::BIT_ACK) begin
              bit_cnt <= 4'h0;
              rd_byte <= rd_byte + 4'h1;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Data line drive, changed while the clock is low; start and stop release it with the clock high
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin : sda_drive
    if (!rst_b) begin
      serial_data_oe <= 1'b0;
    end else if (start_cond || stop_cond) begin
      serial_data_oe <= 1'b0;
    end else if (scl_fall) begin
      if (state == lcdsp_pkg::ST_ADDR && bit_cnt == lcdsp_pkg::BIT_ACK) begin
        serial_data_oe <= addr_hit;
      end else if (state == lcdsp_pkg::ST_WRITE && bit_cnt == lcdsp_pkg::BIT_ACK && !skip) begin
        serial_data_oe <= ack_ok;
      end else if (state == lcdsp_pkg::ST_READ && bit_cnt != lcdsp_pkg::BIT_ACK) begin
        serial_data_oe <= !rd_bit;
      end else begin
        serial_data_oe <= 1'b0;
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  assign serial_data_out = 1'b0;

  // ****************************************************************
  // Byte buffer and segment shift register
  // ****************************************************************
  logic pop;
  logic [lcdsp_pkg::SREG_W-1:0] next_sreg;
  logic [3:0] fill_cnt;
  logic latch_req;
  logic latch_load;
  logic [lcdsp_pkg::SREG_W-1:0] seg_latch;

  lcdsp_fifo #(.W(lcdsp_pkg::BYTE_W), .DEPTH(lcdsp_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr(wr_if.snk),
    .rd(rd_if.src)
  );

  // Draining stalls during read-back so the register holds still
  assign rd_if.ready = (state != lcdsp_pkg::ST_READ);
  assign pop = rd_if.valid && rd_if.ready;
  assign next_sreg = {sreg[lcdsp_pkg::SREG_W-9:0], rd_if.data};

  always_ff @(posedge core_clk or negedge rst_b) begin : shift_store
    if (!rst_b) begin
      sreg <= '0;
    end else if (pop) begin
      sreg <= next_sreg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin : block_count
    if (!rst_b) begin
      fill_cnt <= 4'h0;
    end else if (start_cond) begin
      fill_cnt <= 4'h0;
    end else if (pop) begin
      fill_cnt <= fill_cnt + 4'h1;
    end
  end

  // Pulse request; a new pulse in the serving cycle is kept
  always_ff @(posedge core_clk or negedge rst_b) begin : ext_request
    if (!rst_b) begin
      latch_req <= 1'b0;
    end else if (enb_rise) begin
      latch_req <= 1'b1;
    end else if (latch_load && !auto_mode) begin
      latch_req <= 1'b0;
    end
  end

  // External latch waits for the buffer to empty so no byte is left behind
  always_comb begin
    latch_load = 1'b0;
    if (auto_mode) begin
      latch_load = pop && (fill_cnt == lcdsp_pkg::BLOCK_LAST_BYTE);
    end else begin
      latch_load = latch_req && !rd_if.valid;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin : display_latch
    if (!rst_b) begin
      seg_latch <= '0;
    end else if (latch_load) begin
      seg_latch <= auto_mode ? next_sreg : sreg;
    end
  end

  // ****************************************************************
  // Display multiplexer, paced by the oscillator
  // ****************************************************************
  logic [7:0] div_cnt;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [6:0] grp_idx;

  assign next_phase = phase + 2'h1;
  assign grp_idx = {~next_phase, 5'h1f};

  // Oscillator timing is separate from the serial side
  always_ff @(posedge core_clk or negedge rst_b) begin : plane_mux
    if (!rst_b) begin
      div_cnt <= 8'h00;
      phase <= 2'h0;
      frontplane_outputs <= '0;
      backplane_outputs <= 4'h1;
      osc_output <= 1'b0;
    end else begin
      osc_output <= !osc_s;
      if (osc_rise) begin
        if (div_cnt == lcdsp_pkg::OSC_DIV - 8'h01) begin
          div_cnt <= 8'h00;
          phase <= next_phase;
          backplane_outputs <= 4'h1 << next_phase;
          frontplane_outputs <= seg_latch[grp_idx -: lcdsp_pkg::GROUP_W];
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_start_to_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    start_cond |=> state == lcdsp_pkg::ST_ADDR && bit_cnt == 4'h0)
    else $error("start did not open address phase");

  a_stop_release: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    stop_cond |=> state == lcdsp_pkg::ST_IDLE && !addr_hit ##1 !wr_if.valid)
    else $error("stop did not release addressed state");

  a_push_addressed: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    wr_if.valid |-> addr_hit && $past(state) == lcdsp_pkg::ST_WRITE)
    else $error("byte pushed while not addressed");

  a_plain_no_ack: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !ack_mode_s && $past(!ack_mode_s, 2) && state != lcdsp_pkg::ST_READ |-> !serial_data_oe)
    else $error("plain variant drove the data line");

  a_sda_change_low: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $changed(serial_data_oe) && !$past(start_cond) && !$past(stop_cond) |-> !scl_s)
    else $error("data line changed while clock high");

  a_skip_block: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    scl_rise && skip && state == lcdsp_pkg::ST_WRITE && !start_cond && !stop_cond
      |=> !skip && $stable(data_bits) && $stable(shreg))
    else $error("edge after block was not ignored");

  a_auto_latch: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    pop && auto_mode && fill_cnt == lcdsp_pkg::BLOCK_LAST_BYTE |=> seg_latch == sreg)
    else $error("block of 128 bits not latched");

  a_ext_latch: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $fell(enb_s) && latch_req && state != lcdsp_pkg::ST_READ |-> ##[0:20] latch_load)
    else $error("enable pulse not served");

  a_addr_ack: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    scl_fall && state == lcdsp_pkg::ST_ADDR && bit_cnt == lcdsp_pkg::BIT_ACK && addr_hit
      && !start_cond && !stop_cond |=> serial_data_oe)
    else $error("address match not acknowledged");

  a_read_release: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    scl_fall && state == lcdsp_pkg::ST_READ && bit_cnt == lcdsp_pkg::BIT_ACK |=> !serial_data_oe)
    else $error("read ninth clock not released");

  a_master_flag: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    &strap_s |=> master_role)
    else $error("master role not taken");
endmodule // lcdsp_port

//--- hdl/lcdsp_stream_if.sv
`timescale 1ns/100ps
interface lcdsp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hdl/lcdsp_sync.sv
`timescale 1ns/100ps
module lcdsp_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Lanes
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // Idle level of every lane is high, so reset to ones
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // lcdsp_sync

//--- testbench/lcdsp_host.sv
`timescale 1ns/100ps
module lcdsp_host (
  // Clock
  input wire logic core_clk,
  // Bus pins
  output logic scl,
  output logic sda,
  output logic lat_n,
  input wire logic sda_line,
  // Observed acknowledge or read byte
  output logic got,
  output logic [7:0] got_val
);
  // ****************************************************************
  // Line control
  // ****************************************************************
  // The clock only moves inside frames and rests high between them
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    lat_n = 1'b1;
    got = 1'b0;
    got_val = 8'h00;
  end

  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  task automatic report(input logic [7:0] v);
    got_val = v;
    got = 1'b1;
    @(negedge core_clk);
    got = 1'b0;
  endtask

  task automatic clk_bit(input logic b, output logic seen);
    sda = b;
    half();
    scl = 1'b1;
    half();
    seen = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    half();
    sda = 1'b0;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda = 1'b1;
    half();
  endtask

  task automatic tick();
    logic s;
    clk_bit(1'b1, s);
  endtask

  // ****************************************************************
  // Byte transfers
  // ****************************************************************
  task automatic put_byte(input logic [7:0] b, input logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    if (acked) begin
      clk_bit(1'b1, s);
      report({7'h0, s});
    end
  endtask

  // Data stays released, so the device alone shapes the line
  task automatic get_byte(input logic last);
    logic [7:0] v;
    logic s;
    v = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      v = {v[6:0], s};
    end
    report(v);
    if (last) begin
      // The device owns the line after the ninth pulse, so the stop must use that pulse
      half();
      s = sda_line;
    end else begin
      clk_bit(1'b1, s);
    end
    report({7'h0, s});
  endtask

  // Pulse sits in the clock's idle high phase
  task automatic latch_pulse();
    lat_n = 1'b1;
    half();
    lat_n = 1'b0;
    repeat (30) @(negedge core_clk);
  endtask
endmodule // lcdsp_host

//--- testbench/lcdsp_port_bench.sv
`timescale 1ns/100ps
module lcdsp_port_bench;
  localparam int LIMIT = 40000;
  logic core_clk, rst_b, scl, sda, lat_n, got, osc, ack_mode, master_role, oe, dout, osc_o;
  logic [7:0] got_val;
  logic [2:0] strap;
  logic [31:0] fp;
  logic [3:0] bp, bp_prev;
  logic [2:0] osc_hist;
  logic [127:0] img, shown;
  logic [7:0] exp_q[$];
  logic [31:0] fp_q[$];
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  wire logic sda_line;
  // Open drain with pull-up: the device can only pull low
  assign sda_line = sda & ~(oe & ~dout);

  lcdsp_host host (.core_clk(core_clk), .scl(scl), .sda(sda), .lat_n(lat_n),
    .sda_line(sda_line), .got(got), .got_val(got_val));

  lcdsp_port DUT (.core_clk(core_clk), .rst_b(rst_b), .serial_clock_in(scl),
    .serial_data_in(sda_line), .serial_data_out(dout), .serial_data_oe(oe),
    .latch_enable_n(lat_n), .addr_strap_msb(strap[2]), .addr_strap_mid(strap[1]),
    .addr_strap_lsb(strap[0]), .ack_mode(ack_mode), .master_role(master_role),
    .osc_input(osc), .osc_output(osc_o), .frontplane_outputs(fp),
    .backplane_outputs(bp));

  // ****************************************************************
  // Clocks, checking and ending
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    osc = 1'b0;
    forever #100 osc = ~osc;
  end

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      test_done();
    end
  end

  always @(posedge core_clk) osc_hist <= {osc_hist[1:0], osc};

  always @(posedge got) begin
    if (exp_q.size() > 0) begin
      check({24'h0, got_val}, {24'h0, exp_q.pop_front()});
    end else begin
      check({24'h0, got_val}, 32'hffffffff);
    end
  end

  // Group k belongs to backplane k; a queue entry waits for its phase
  always @(negedge core_clk) begin
    bp_prev <= bp;
    if (bp !== bp_prev && fp_q.size() > 0 && bp === (4'h1 << (4 - fp_q.size()))) begin
      check(fp, fp_q.pop_front());
    end
    if (rst_b === 1'b1 && ack_mode === 1'b0) begin
      check({31'h0, oe}, 32'h0);
    end
    if (rst_b === 1'b1 && cycles > 8) begin
      check({31'h0, osc_o}, {31'h0, ~osc_hist[2]});
    end
  end

  task automatic show(input logic [127:0] v);
    repeat (30) @(negedge core_clk);
    for (int k = 0; k < 4; k++) fp_q.push_back(v[127 - 32 * k -: 32]);
    for (int t = 0; t < 600 && fp_q.size() > 0; t++) @(negedge core_clk);
    if (fp_q.size() > 0) begin
      check(32'(fp_q.size()), 32'h0);
      fp_q.delete();
    end
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic send_block(input logic [7:0] addr, input logic acked, input logic ok,
      input logic opened, input int n);
    logic [7:0] b;
    if (opened) begin
      host.start();
      if (acked) exp_q.push_back({7'h0, !ok});
      host.put_byte(addr, acked);
    end
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom());
      if (ok) img = {img[119:0], b};
      if (acked) exp_q.push_back({7'h0, !ok});
      host.put_byte(b, acked);
    end
  endtask

  initial begin
    rst_b = 1'b0;
    ack_mode = 1'b1;
    strap = 3'h7;
    img = '0;
    void'($urandom(32'he10b));
    repeat (4) @(negedge core_clk);
    check({31'h0, oe}, 32'h0);
    check({28'h0, bp}, 32'h1);
    rst_b = 1'b1;
    repeat (8) @(negedge core_clk);
    check({31'h0, master_role}, 32'h1);
    $display("test reset done");
    send_block(8'h7e, 1'b1, 1'b1, 1'b1, 16);
    host.stop();
    show(img);
    shown = img;
    $display("test write done");
    host.start();
    exp_q.push_back(8'h00);
    host.put_byte(8'h7f, 1'b1);
    for (int i = 15; i >= 0; i--) begin
      exp_q.push_back(img[8 * i +: 8]);
      exp_q.push_back(8'h01);
      host.get_byte(i == 0);
    end
    host.stop();
    $display("test read done");
    send_block(8'h7e, 1'b1, 1'b1, 1'b1, 3);
    host.stop();
    send_block(8'h70, 1'b1, 1'b0, 1'b1, 2);
    host.stop();
    show(shown);
    $display("test abort done");
    host.lat_n = 1'b0;
    send_block(8'h7e, 1'b1, 1'b1, 1'b1, 16);
    host.tick();
    send_block(8'h00, 1'b1, 1'b1, 1'b0, 16);
    host.stop();
    show(shown);
    host.latch_pulse();
    show(img);
    $display("test external latch done");
    ack_mode = 1'b0;
    host.lat_n = 1'b1;
    repeat (30) @(negedge core_clk);
    send_block(8'h7e, 1'b0, 1'b1, 1'b1, 16);
    host.tick();
    send_block(8'h00, 1'b0, 1'b1, 1'b0, 16);
    host.stop();
    show(img);
    $display("test plain done");
    strap = 3'h5;
    repeat (8) @(negedge core_clk);
    check({31'h0, master_role}, 32'h0);
    $display("test strap done");
    check(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule // lcdsp_port_bench
